// ===== core/ffm_pkg.sv
/*
 * Shared constants for the freefall/motion detector: register indices,
 * field positions, reset values and the sample width.
 * Assumes an AXI4-Lite master with 32-bit data; each register index sits
 * at byte address four times the index.
 */
package ffm_pkg;

    // bus geometry
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          REG_W        = 8;
    localparam int          SAMPLE_W     = 8;
    localparam int          AXES         = 3;
    localparam int          IDX_LSB      = 2;

    // register indices, byte address is four times these
    localparam logic [5:0]  IDX_CONFIG   = 6'h15;
    localparam logic [5:0]  IDX_STATUS   = 6'h16;
    localparam logic [5:0]  IDX_THRESH   = 6'h17;
    localparam logic [5:0]  IDX_COUNT    = 6'h18;
    localparam logic [5:0]  IDX_LOWNOISE = 6'h2a;
    localparam logic [5:0]  IDX_IRQ      = 6'h2c;

    // config fields
    localparam int          CFG_LATCH    = 7;
    localparam int          CFG_OR_SEL   = 6;
    localparam int          CFG_EN_LSB   = 3;
    localparam logic [7:0]  CFG_WMASK    = 8'hf8;

    // threshold fields
    localparam int          THS_CLRMODE  = 7;
    localparam logic [6:0]  THS_LN_MAX   = 7'h3f;

    // status fields
    localparam int          ST_EA        = 7;

    // own registers: low-noise bit, irq enable and route
    localparam int          LN_BIT       = 0;
    localparam int          IRQ_EN_BIT   = 0;
    localparam int          IRQ_ROUTE    = 1;

    // reset values
    localparam logic [7:0]  RST_REG      = 8'h00;

    // axi responses
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage : ffm_pkg

// ===== core/ffm_axis_cmp.sv
/*
 * One axis of the detector: magnitude of a signed sample against the
 * threshold, giving low, high and sign, all gated by the axis enable.
 * Assumes the sample is in threshold units and stable while it is used.
 */
`timescale 1ns/1ps
module ffm_axis_cmp #(
    parameter int SAMPLE_W = ffm_pkg::SAMPLE_W
) (
    // sample and setup
    input  wire logic signed [SAMPLE_W-1:0] sample,
    input  wire logic        [6:0]          thresh,
    input  wire logic                       enable,
    // results
    output logic                            is_low,
    output logic                            is_high,
    output logic                            is_neg
);
    import ffm_pkg::*;

    logic [SAMPLE_W-1:0] mag;
    logic [SAMPLE_W:0]   mag_x;
    logic [SAMPLE_W:0]   ths_x;

    // two's complement magnitude; most negative value still fits unsigned
    assign mag     = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : SAMPLE_W'(sample);
    assign mag_x   = {1'b0, mag};
    assign ths_x   = (SAMPLE_W + 1)'(thresh);
    assign is_low  = enable & (mag_x <= ths_x);   // R2
    assign is_high = enable & (mag_x > ths_x);    // R3
    assign is_neg  = enable & sample[SAMPLE_W-1];

endmodule : ffm_axis_cmp

// ===== core/ffm_detector.sv
/*
 * Freefall/motion detector with an AXI4-Lite register slave.
 * Assumes samples come from logic on aclk, in threshold units, valid with
 * a one-cycle sample strobe per output-rate sample.
 */
// What this block does
// R1 - combine select 0 ANDs enabled low axes, 1 ORs enabled high axes
// R2 - freefall axis is low when sample magnitude is at or below threshold
// R3 - motion axis is high when sample magnitude exceeds threshold
// R4 - per-axis enable bits include or exclude each axis
// R5 - event-active sets on debounced combined condition, zero at reset
// R6 - event-active with irq enable and route drives interrupt pins
// R7 - axis event flag reads 1 when enabled axis meets its condition
// R8 - axis polarity reads 0 for positive, 1 for negative sample
// R9 - flags and polarity of a disabled axis always read zero
// R10 - latch bit 0 gives real-time status
// R11 - latch bit 1 freezes flags when event-active sets, until status read
// R12 - latched status read clears event-active and all status bits
// R13 - threshold is 7-bit unsigned, 0 to 127 counts
// R14 - low-noise bit caps the effective threshold at about 4g
// R15 - clear mode 1 zeroes debounce counter when condition is false
// R16 - clear mode 0 decrements counter when false, stopping at zero
// R17 - event flag sets when counter reaches programmed count
// R18 - counter saturates at programmed count
// R19 - debounce step is one output-rate sample
// R20 - threshold, clear mode and count reset to zero
// R21 - all axis enables zero disables detection
// R22 - non-latched status read clears nothing
// R23 - latched status read also clears the debounce counter
// R24 - non-latched with clear mode 1, event-active drops with the condition
// R25 - detection updates once per sample strobe
// R26 - polarity comes from the sample that last updated the flag
`timescale 1ns/1ps
module ffm_detector #(
    parameter int SAMPLE_W = ffm_pkg::SAMPLE_W
) (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic [ffm_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // axi4-lite write data
    input  wire logic [ffm_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [ffm_pkg::DATA_W/8-1:0]  s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read address
    input  wire logic [ffm_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // axi4-lite read data
    output logic [ffm_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // acceleration samples
    input  wire logic                          sample_strobe,
    input  wire logic signed [SAMPLE_W-1:0]    x_sample,
    input  wire logic signed [SAMPLE_W-1:0]    y_sample,
    input  wire logic signed [SAMPLE_W-1:0]    z_sample,
    // interrupt pins
    output logic                               ffmt_int1,
    output logic                               ffmt_int2
);
    import ffm_pkg::*;

    // registers
    logic [REG_W-1:0]          ffmt_config_r;
    logic [REG_W-1:0]          ffmt_threshold_r;
    logic [REG_W-1:0]          ffmt_debounce_count_r;
    logic                      low_noise_r;
    logic                      ffmt_irq_enable_r;
    logic                      ffmt_irq_route_r;

    // detector state
    logic [REG_W-1:0]          cnt_r, cnt_nxt, cnt_b;
    logic                      event_active_r, ea_nxt, ea_b;
    logic [AXES-1:0]           flag_r, flag_nxt, flag_b;
    logic [AXES-1:0]           pol_r, pol_nxt, pol_b;

    // bus side
    logic                      aw_have_r;
    logic                      w_have_r;
    logic [ADDR_W-1:0]         awaddr_r;
    logic [REG_W-1:0]          wdata_r;
    logic                      wstrb0_r;
    logic                      do_write;
    logic [5:0]                wr_idx;
    logic [5:0]                rd_idx;
    logic                      ar_hs;
    logic                      stat_rd;
    logic                      rd_clr;

    // combinational detector terms
    logic                      latch_enable;
    logic                      or_and_select;
    logic                      debounce_clear_mode;
    logic [AXES-1:0]           axis_en;
    logic [6:0]                ths_eff;
    logic [AXES-1:0]           ax_low, ax_high, ax_neg, ax_hit;
    logic                      cond;
    logic [REG_W-1:0]          stat_word;
    logic signed [SAMPLE_W-1:0] samp [AXES];

    assign latch_enable        = ffmt_config_r[CFG_LATCH];
    assign or_and_select       = ffmt_config_r[CFG_OR_SEL];
    assign debounce_clear_mode = ffmt_threshold_r[THS_CLRMODE];
    assign axis_en             = ffmt_config_r[CFG_EN_LSB +: AXES];   // bit0 x, bit1 y, bit2 z
    assign samp[0]             = x_sample;
    assign samp[1]             = y_sample;
    assign samp[2]             = z_sample;

    // low-noise caps the usable threshold at half the 8g span
    assign ths_eff = (low_noise_r && ffmt_threshold_r[6:0] > THS_LN_MAX) ?
                     THS_LN_MAX : ffmt_threshold_r[6:0];   // R13 R14

    // one comparator per axis
    genvar gi;
    generate
        for (gi = 0; gi < AXES; gi++) begin : g_axis
            ffm_axis_cmp #(
                .SAMPLE_W (SAMPLE_W)
            ) u_cmp (
                .sample   (samp[gi]),
                .thresh   (ths_eff),
                .enable   (axis_en[gi]),              // R4
                .is_low   (ax_low[gi]),
                .is_high  (ax_high[gi]),
                .is_neg   (ax_neg[gi])
            );
            assign ax_hit[gi] = or_and_select ? ax_high[gi] : ax_low[gi];   // R7
        end
    endgenerate

    // combined condition; disabled axes count as satisfied for AND only
    assign cond = (|axis_en) &&                                    // R21
                  (or_and_select ? (|ax_high) : (&(ax_low | ~axis_en)));   // R1

    // status view, disabled axes masked live
    assign stat_word = {event_active_r, 1'b0,
                        flag_r[2] & axis_en[2], pol_r[2] & axis_en[2],
                        flag_r[1] & axis_en[1], pol_r[1] & axis_en[1],
                        flag_r[0] & axis_en[0], pol_r[0] & axis_en[0]};   // R9

    // write path: address and data accepted in any order
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_idx   = awaddr_r[IDX_LSB +: 6];
    assign rd_idx   = s_axi_araddr[IDX_LSB +: 6];
    assign ar_hs    = s_axi_arvalid && s_axi_arready;
    assign stat_rd  = ar_hs && (s_axi_araddr[1:0] == 2'b00) && (rd_idx == IDX_STATUS);
    assign rd_clr   = stat_rd && latch_enable;   // R12 R22

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            awaddr_r      <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r     <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_have_r     <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_bvalid;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r     <= 1'b0;
            wdata_r      <= '0;
            wstrb0_r     <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r     <= 1'b1;
            wdata_r      <= s_axi_wdata[REG_W-1:0];
            wstrb0_r     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_have_r     <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_r && !s_axi_bvalid;
        end
    end

    // register writes and response; only lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ffmt_config_r         <= RST_REG;
            ffmt_threshold_r      <= RST_REG;              // R20
            ffmt_debounce_count_r <= RST_REG;              // R20
            low_noise_r           <= 1'b0;
            ffmt_irq_enable_r     <= 1'b0;
            ffmt_irq_route_r      <= 1'b0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            if (awaddr_r[1:0] != 2'b00) begin
                s_axi_bresp <= RESP_SLVERR;
            end else if (wr_idx == IDX_CONFIG) begin
                if (wstrb0_r) ffmt_config_r <= wdata_r & CFG_WMASK;
            end else if (wr_idx == IDX_THRESH) begin
                if (wstrb0_r) ffmt_threshold_r <= wdata_r;
            end else if (wr_idx == IDX_COUNT) begin
                if (wstrb0_r) ffmt_debounce_count_r <= wdata_r;
            end else if (wr_idx == IDX_LOWNOISE) begin
                if (wstrb0_r) low_noise_r <= wdata_r[LN_BIT];
            end else if (wr_idx == IDX_IRQ) begin
                if (wstrb0_r) begin
                    ffmt_irq_enable_r <= wdata_r[IRQ_EN_BIT];
                    ffmt_irq_route_r  <= wdata_r[IRQ_ROUTE];
                end
            end else if (wr_idx == IDX_STATUS) begin
                s_axi_bresp <= RESP_OKAY;                  // read-only, write ignored
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel; one read at a time, arready drops while data waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
            if (s_axi_araddr[1:0] != 2'b00) begin
                s_axi_rresp <= RESP_SLVERR;
            end else if (rd_idx == IDX_CONFIG) begin
                s_axi_rdata[REG_W-1:0] <= ffmt_config_r;
            end else if (rd_idx == IDX_STATUS) begin
                s_axi_rdata[REG_W-1:0] <= stat_word;
            end else if (rd_idx == IDX_THRESH) begin
                s_axi_rdata[REG_W-1:0] <= ffmt_threshold_r;
            end else if (rd_idx == IDX_COUNT) begin
                s_axi_rdata[REG_W-1:0] <= ffmt_debounce_count_r;
            end else if (rd_idx == IDX_LOWNOISE) begin
                s_axi_rdata[LN_BIT] <= low_noise_r;
            end else if (rd_idx == IDX_IRQ) begin
                s_axi_rdata[IRQ_EN_BIT] <= ffmt_irq_enable_r;
                s_axi_rdata[IRQ_ROUTE]  <= ffmt_irq_route_r;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // debounce and status next state; a strobe in the read-clear cycle is
    // applied after the clear so the new sample is never lost
    always_comb begin
        cnt_b    = rd_clr ? '0 : cnt_r;               // R23
        ea_b     = rd_clr ? 1'b0 : event_active_r;    // R12
        flag_b   = rd_clr ? '0 : flag_r;
        pol_b    = rd_clr ? '0 : pol_r;
        cnt_nxt  = cnt_b;
        ea_nxt   = ea_b;
        flag_nxt = flag_b;
        pol_nxt  = pol_b;
        if (sample_strobe) begin                      // R25 R19
            if (cond) begin
                cnt_nxt = (cnt_b < ffmt_debounce_count_r) ?
                          REG_W'(cnt_b + 1'b1) : ffmt_debounce_count_r;   // R18
            end else if (debounce_clear_mode) begin
                cnt_nxt = '0;                         // R15
            end else if (cnt_b != '0) begin
                cnt_nxt = REG_W'(cnt_b - 1'b1);       // R16
            end
            if (latch_enable) begin
                if (!ea_b) begin                      // R11
                    flag_nxt = ax_hit;
                    pol_nxt  = ax_neg;                // R8 R26
                    ea_nxt   = cond && (cnt_nxt == ffmt_debounce_count_r);   // R17
                end
            end else begin
                flag_nxt = ax_hit;                    // R10
                pol_nxt  = ax_neg;                    // R26
                if (cond) begin
                    ea_nxt = ea_b || (cnt_nxt == ffmt_debounce_count_r);   // R5 R17
                end else if (debounce_clear_mode) begin
                    ea_nxt = 1'b0;                    // R24
                end else begin
                    ea_nxt = ea_b && (cnt_nxt != '0);
                end
            end
        end
    end

    // detector state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r          <= '0;
            event_active_r <= 1'b0;                   // R5
            flag_r         <= '0;
            pol_r          <= '0;
        end else begin
            cnt_r          <= cnt_nxt;
            event_active_r <= ea_nxt;
            flag_r         <= flag_nxt;
            pol_r          <= pol_nxt;
        end
    end

    // interrupt pins: route 1 selects pin 1, route 0 pin 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ffmt_int1 <= 1'b0;
            ffmt_int2 <= 1'b0;
        end else begin
            ffmt_int1 <= event_active_r && ffmt_irq_enable_r && ffmt_irq_route_r;    // R6
            ffmt_int2 <= event_active_r && ffmt_irq_enable_r && !ffmt_irq_route_r;   // R6
        end
    end
    // checks; reset masks them, read clears kept out where they would race a step
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_clear_mode; sample_strobe && !cond && debounce_clear_mode |=> cnt_r == '0; endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("counter not cleared");   // R15
    property p_decrement; sample_strobe && !cond && !debounce_clear_mode && !rd_clr && cnt_r != '0
        |=> cnt_r == REG_W'($past(cnt_r) - 1'b1); endproperty
    a_decrement: assert property (p_decrement) else $error("counter not decremented");   // R16
    property p_saturate; sample_strobe && cond |=> cnt_r <= $past(ffmt_debounce_count_r); endproperty
    a_saturate: assert property (p_saturate) else $error("counter above count");   // R18
    property p_read_clear; rd_clr && !sample_strobe |=> {event_active_r, flag_r, pol_r, cnt_r} == '0; endproperty
    a_read_clear: assert property (p_read_clear) else $error("latched read did not clear");   // R12
    property p_read_keep; stat_rd && !latch_enable && !sample_strobe |=> $stable({event_active_r, cnt_r}); endproperty
    a_read_keep: assert property (p_read_keep) else $error("live read disturbed state");   // R22
    property p_freeze; latch_enable && event_active_r && !rd_clr |=> $stable({flag_r, pol_r}); endproperty
    a_freeze: assert property (p_freeze) else $error("latched flags moved");   // R11
    property p_mask; (stat_word[5:0] & ~{{2{axis_en[2]}}, {2{axis_en[1]}}, {2{axis_en[0]}}}) == '0; endproperty
    a_mask: assert property (p_mask) else $error("disabled axis bit visible");   // R9
    property p_disabled; axis_en == '0 && !event_active_r |=> !event_active_r; endproperty
    a_disabled: assert property (p_disabled) else $error("detection while disabled");   // R21
    property p_irq; event_active_r && ffmt_irq_enable_r
        |=> (ffmt_int1 == $past(ffmt_irq_route_r)) && (ffmt_int2 != $past(ffmt_irq_route_r)); endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised on routed pin");   // R6
    property p_no_strobe; !sample_strobe && !rd_clr |=> $stable(cnt_r); endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("counter moved between samples");   // R25
    property p_cv_latched; latch_enable && $rose(event_active_r); endproperty
    c_latched: cover property (p_cv_latched);
    property p_cv_motion; !latch_enable && or_and_select && $rose(event_active_r); endproperty
    c_motion: cover property (p_cv_motion);
    property p_cv_readclr; rd_clr && event_active_r; endproperty
    c_readclr: cover property (p_cv_readclr);

endmodule : ffm_detector

// ===== sim/ffm_src.sv
/* sample model: the sensor front end, one strobe per fire pulse; assumes fire is one aclk cycle wide */
`timescale 1ns/1ps
module ffm_src (
    // clock
    input  wire logic       aclk,
    // bench request
    input  wire logic       fire,
    input  wire logic [7:0] x_in,
    input  wire logic [7:0] y_in,
    input  wire logic [7:0] z_in,
    // detector side
    output logic            strobe,
    output logic [7:0]      x_out,
    output logic [7:0]      y_out,
    output logic [7:0]      z_out
);
    logic        s_r = 1'b0;
    logic [23:0] v_r = 24'h000000;
    // capture on fire, strobe one cycle later
    always @(posedge aclk) begin
        s_r <= fire;
        if (fire) v_r <= {x_in, y_in, z_in};
    end
    // off the strobe the bus shows junk, so stale data is never trusted
    assign strobe = s_r;
    assign {x_out, y_out, z_out} = s_r ? v_r : ~v_r;
endmodule : ffm_src

// ===== sim/tb_top.sv
/* bench top: axi4-lite host tasks, sample model and checks; assumes 100 ns aclk, sync active-low reset */
`timescale 1ns/1ps
module tb_top;
    import ffm_pkg::*;
    // bench and design signals
    logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic        awr, wrdy, bv, arr, rv, strb, int1, int2;
    logic [1:0]  bresp, rresp, gresp;
    logic [5:0]  idx = 6'h00;
    logic [7:0]  xi = 8'h00, yi = 8'h00, zi = 8'h00, xs, ys, zs;
    logic [31:0] wd = 32'h0, rd, got;
    int          fail_count = 0, tests_run = 0;
    // 10 mhz clock
    always #50 aclk = ~aclk;
    ffm_src i_src (.aclk(aclk), .fire(fire), .x_in(xi), .y_in(yi), .z_in(zi), .strobe(strb), .x_out(xs),
        .y_out(ys), .z_out(zs));
    ffm_detector i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr({idx, 2'b00}), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_arprot(3'h0),
        .s_axi_araddr({idx, 2'b00}), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .sample_strobe(strb), .x_sample(xs),
        .y_sample(ys), .z_sample(zs), .ffmt_int1(int1), .ffmt_int2(int2));
    // verdict and end of run
    task finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) fail_count++;
        if (s !== e) $display("Error at %0t: got %h, expected %h", $time, s, e);
    endtask : chk
    // one axi4-lite transfer, a write when w is set; a hang ends the run
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
        logic a, b, c, e = 1'b0;
        @(posedge aclk);
        {idx, wd} <= {i, 24'h0, d};
        {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
        for (int n = 0; n < 50 && !e; n++) begin
            @(negedge aclk);
            {a, b, c, e} = {awv & awr, wv & wrdy, arv & arr, bv | rv};
            {gresp, got} = {w ? bresp : rresp, rd};
            @(posedge aclk);
            {awv, wv, arv, bry, rry} <= {awv & !a, wv & !b, arv & !c, bry & !e, rry & !e};
        end
        chk({31'h0, e}, 32'h1);
        if (!e) finish_test();
    endtask : bus
    // one sample through the model
    task smp(input logic [7:0] x, y, z);
        @(posedge aclk);
        {xi, yi, zi, fire} <= {x, y, z, 1'b1};
        @(posedge aclk);
        fire <= 1'b0;
    endtask : smp
    // status read checked against one byte
    task st(input logic [7:0] e);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(got, {24'h0, e});
    endtask : st
    // reset values, then live motion on x with y and z disabled but loud
    task s_motion;
        bus(1'b0, IDX_THRESH, 8'h00);
        chk(got, 32'h0);
        st(8'h00);
        bus(1'b1, IDX_IRQ, 8'h03);
        bus(1'b1, IDX_THRESH, 8'h8a);
        bus(1'b1, IDX_COUNT, 8'h02);
        bus(1'b1, IDX_CONFIG, 8'h48);
        smp(8'hec, 8'h9c, 8'h9c);
        st(8'h03);
        smp(8'hec, 8'h9c, 8'h9c);
        repeat (3) @(negedge aclk);
        chk({30'h0, int2, int1}, 32'h1);
        st(8'h83);
        st(8'h83);
        smp(8'h0a, 8'h9c, 8'h9c);
        st(8'h00);
    endtask : s_motion
    // latched freefall on x and y in decrement mode
    task s_latch;
        bus(1'b1, IDX_THRESH, 8'h0a);
        bus(1'b1, IDX_CONFIG, 8'h98);
        smp(8'h0a, 8'hf6, 8'h64);
        st(8'h0e);
        smp(8'h0a, 8'hf6, 8'h64);
        smp(8'h0a, 8'hf6, 8'h64);
        smp(8'h64, 8'h64, 8'h00);
        st(8'h8e);
        st(8'h00);
        smp(8'h0a, 8'hf6, 8'h00);
        st(8'h0e);
    endtask : s_latch
    // low-noise cap, no axis enabled, unmapped read
    task s_misc;
        bus(1'b1, IDX_CONFIG, 8'h48);
        bus(1'b1, IDX_LOWNOISE, 8'h01);
        bus(1'b1, IDX_THRESH, 8'he4);
        bus(1'b1, IDX_COUNT, 8'h00);
        smp(8'h46, 8'h00, 8'h00);
        st(8'h82);
        bus(1'b1, IDX_IRQ, 8'h01);
        @(negedge aclk);
        chk({30'h0, int2, int1}, 32'h2);
        bus(1'b1, IDX_CONFIG, 8'h00);
        smp(8'h9c, 8'h9c, 8'h9c);
        st(8'h00);
        bus(1'b0, 6'h01, 8'h00);
        chk({30'h0, gresp}, {30'h0, RESP_SLVERR});
        // mid-run reset must bring threshold and clear mode back to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        bus(1'b0, IDX_THRESH, 8'h00);
        chk(got, 32'h0);
    endtask : s_misc
    // reset held five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        s_motion();
        s_latch();
        s_misc();
        finish_test();
    end
endmodule : tb_top
